// >>> flash_host.sv
`timescale 1ns/1ps
module flash_host
    import flash_host_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire dev_in_s     dev_i,
    output dev_out_s         dev_o
);
    typedef enum logic [5:0] {
        S_IDLE = 6'b000001,
        S_EE   = 6'b000010,
        S_CTRL = 6'b000100,
        S_ISS  = 6'b001000,
        S_FIN  = 6'b010000,
        S_CAPT = 6'b100000
    } state_e;

    state_e      st_q;
    dev_out_s    dev_q;
    logic [31:0] prdata_q;
    logic        pready_q;
    logic        pslverr_q;
    logic [15:0] z_q;
    logic [15:0] data_q;
    logic [2:0]  op_q;
    logic        done_q;
    logic        ref_q;
    logic [7:0]  res_q;
    logic [63:0] loaded_q;
    logic [6:0]  erased_pg_q;
    logic        erased_ok_q;

    wire setup     = psel && !penable && !pready_q;
    wire access    = psel && penable && pready_q;
    wire wr_acc    = access && pwrite;
    wire hit_cmd   = paddr == REG_CMD;
    wire hit_addr  = paddr == REG_ADDR;
    wire hit_data  = paddr == REG_DATA;
    wire hit_stat  = paddr == REG_STAT;
    wire mapped    = hit_cmd || hit_addr || hit_data || hit_stat;
    wire idle      = st_q == S_IDLE;
    wire dev_en    = dev_i.ctrl_rdata[EN_BIT];
    wire [5:0] widx = z_q[WORD_HI:WORD_LO];
    wire [6:0] pg   = z_q[PAGE_HI:PAGE_LO];
    wire [2:0] new_op = pwdata[2:0];
    wire start     = wr_acc && hit_cmd && idle && new_op != 3'h0;
    // host-side refusals of illegal software sequences
    wire dup_load  = new_op == OP_LOAD && loaded_q[widx];
    wire bad_write = new_op == OP_WRITE
                  && !(erased_ok_q && erased_pg_q == pg);
    wire refuse    = start && (dup_load || bad_write);
    wire go        = start && !refuse;
    wire rd_op     = op_q == OP_FUSE || op_q == OP_SIG;
    // ready to write control: eeprom idle and prior op done
    wire ee_ok     = !dev_i.eeprom_write_busy && !dev_en;

    logic [7:0]  ctrl_pat;
    logic [15:0] z_out;
    logic [15:0] r_out;
    logic [31:0] rd_word;
    always_comb begin
        ctrl_pat = CTRL_LOAD;
        z_out    = z_q;
        r_out    = data_q;
        case (op_q)
            OP_LOAD:  ctrl_pat = CTRL_LOAD;
            OP_ERASE: ctrl_pat = CTRL_ERASE;
            OP_WRITE: ctrl_pat = CTRL_WRITE;
            OP_LOCK: begin
                ctrl_pat = CTRL_LOCK;
                z_out    = LOCK_Z;
                r_out    = {8'h00, data_q[7:0] | LOCK_KEEP};
            end
            OP_REEN:  ctrl_pat = CTRL_REEN;
            OP_FUSE:  ctrl_pat = CTRL_LOCK;
            OP_SIG:   ctrl_pat = CTRL_SIG;
            default:  ctrl_pat = CTRL_LOAD;
        endcase
    end

    always_comb begin
        rd_word = RST_WORD;
        if (hit_addr) begin
            rd_word[15:0] = z_q;
        end else if (hit_data) begin
            rd_word[15:0] = data_q;
        end else if (hit_stat) begin
            rd_word[ST_BUSY]         = !idle;
            rd_word[ST_DONE]         = done_q;
            rd_word[ST_REF]          = ref_q;
            rd_word[ST_RES+7:ST_RES] = res_q;
            rd_word[ST_CTRL+7:ST_CTRL] = dev_i.ctrl_rdata;
        end
    end

    // apb slave: one wait-free access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= RST_WORD;
        end else if (ce) begin
            pready_q  <= setup;
            pslverr_q <= setup && !(psel && mapped);
            if (setup) begin
                prdata_q <= rd_word;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            z_q    <= 16'h0000;
            data_q <= 16'h0000;
        end else if (ce && wr_acc && idle) begin
            if (hit_addr) begin
                z_q <= pwdata[15:0];
            end
            if (hit_data) begin
                data_q <= pwdata[15:0];
            end
        end
    end

    // sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q   <= S_IDLE;
            op_q   <= 3'h0;
            done_q <= 1'b0;
            ref_q  <= 1'b0;
            res_q  <= 8'h00;
            dev_q  <= '0;
        end else if (ce) begin
            dev_q.ctrl_wr <= 1'b0;
            dev_q.spm     <= 1'b0;
            dev_q.lpm     <= 1'b0;
            case (st_q)
                S_IDLE: begin
                    if (start) begin
                        ref_q  <= refuse;
                        done_q <= refuse;
                    end
                    if (go) begin
                        op_q <= new_op;
                        st_q <= S_EE;
                    end
                end
                S_EE: begin
                    if (ee_ok) begin
                        dev_q.ctrl_wr    <= 1'b1;
                        dev_q.ctrl_wdata <= ctrl_pat;
                        dev_q.z          <= z_out;
                        dev_q.r          <= r_out;
                        st_q             <= S_CTRL;
                    end
                end
                S_CTRL: begin
                    // strike inside the armed window
                    dev_q.spm <= !rd_op;
                    dev_q.lpm <= rd_op;
                    st_q      <= rd_op ? S_CAPT : S_ISS;
                end
                S_ISS: begin
                    st_q <= S_FIN;
                end
                S_CAPT: begin
                    st_q <= S_FIN;
                end
                S_FIN: begin
                    if (rd_op) begin
                        res_q  <= dev_i.lpm_data;
                        done_q <= 1'b1;
                        st_q   <= S_IDLE;
                    end else if (!dev_en) begin
                        done_q <= 1'b1;
                        st_q   <= S_IDLE;
                    end
                end
                default: st_q <= S_IDLE;
            endcase
        end
    end

    // shadow of buffer and erased page
    wire spm_now = ce && dev_q.spm;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            loaded_q    <= 64'h0;
            erased_pg_q <= 7'h00;
            erased_ok_q <= 1'b0;
        end else if (spm_now) begin
            case (op_q)
                OP_LOAD: loaded_q[dev_q.z[WORD_HI:WORD_LO]] <= 1'b1;
                OP_ERASE: begin
                    erased_pg_q <= dev_q.z[PAGE_HI:PAGE_LO];
                    erased_ok_q <= 1'b1;
                end
                OP_WRITE: begin
                    loaded_q    <= 64'h0;
                    erased_ok_q <= 1'b0;
                end
                OP_REEN: loaded_q <= 64'h0;
                default: erased_ok_q <= erased_ok_q;
            endcase
        end
    end

    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;
    assign dev_o   = dev_q;

    sequence ctrl_store_s;
        dev_o.ctrl_wr && dev_o.ctrl_wdata != CTRL_SIG && !rd_op;
    endsequence
    sequence ctrl_read_s;
        dev_o.ctrl_wr && rd_op;
    endsequence
    // control write, single strike, strike gone
    sequence store_step_s;
        dev_o.ctrl_wr ##1 dev_o.spm ##1 !dev_o.spm;
    endsequence
    sequence read_step_s;
        dev_o.ctrl_wr ##1 dev_o.lpm ##1 !dev_o.lpm;
    endsequence

    spm_window_a: assert property (
        @(posedge pclk) disable iff (!presetn || !ce)
        ctrl_store_s |-> ##[1:4] dev_o.spm)
        else $error("store not issued inside window");
    lpm_window_a: assert property (
        @(posedge pclk) disable iff (!presetn || !ce)
        ctrl_read_s |-> ##[1:3] dev_o.lpm)
        else $error("load not issued inside window");
    ee_quiet_a: assert property (
        @(posedge pclk) disable iff (!presetn || !ce)
        dev_o.ctrl_wr |-> $past(!dev_i.eeprom_write_busy))
        else $error("control written while eeprom busy");
    lock_args_a: assert property (
        @(posedge pclk) disable iff (!presetn || !ce)
        dev_o.spm && dev_o.ctrl_wdata == CTRL_LOCK
        |-> dev_o.z == LOCK_Z && (dev_o.r[7:0] & LOCK_KEEP) == LOCK_KEEP)
        else $error("lock set arguments wrong");
    load_once_a: assert property (
        @(posedge pclk) disable iff (!presetn || !ce)
        dev_o.spm && dev_o.ctrl_wdata == CTRL_LOAD
        |-> !loaded_q[dev_o.z[WORD_HI:WORD_LO]])
        else $error("buffer word loaded twice");
    erase_first_a: assert property (
        @(posedge pclk) disable iff (!presetn || !ce)
        dev_o.spm && dev_o.ctrl_wdata == CTRL_WRITE
        |-> erased_ok_q && erased_pg_q == dev_o.z[PAGE_HI:PAGE_LO])
        else $error("page write without matching erase");
    load_data_a: assert property (
        @(posedge pclk) disable iff (!presetn || !ce)
        dev_o.spm && dev_o.ctrl_wdata == CTRL_LOAD
        |-> dev_o.r == data_q && dev_o.z == z_q)
        else $error("load word or pointer wrong");
    write_clears_a: assert property (
        @(posedge pclk) disable iff (!presetn || !ce)
        dev_o.spm && dev_o.ctrl_wdata == CTRL_WRITE
        |=> loaded_q == 64'h0 && !erased_ok_q)
        else $error("shadow not cleared after write");
    reen_clears_a: assert property (
        @(posedge pclk) disable iff (!presetn || !ce)
        dev_o.ctrl_wr && dev_o.ctrl_wdata == CTRL_REEN
        |-> ##1 dev_o.spm ##1 loaded_q == 64'h0)
        else $error("reenable did not follow through");

    // strike timing and host bookkeeping
    store_step_a: assert property (
        @(posedge pclk) disable iff (!presetn || !ce)
        dev_o.ctrl_wr && !rd_op |-> store_step_s)
        else $error("store strike not one cycle after control");
    read_step_a: assert property (
        @(posedge pclk) disable iff (!presetn || !ce)
        dev_o.ctrl_wr && rd_op |-> read_step_s)
        else $error("load strike not one cycle after control");
    en_clear_a: assert property (
        @(posedge pclk) disable iff (!presetn || !ce)
        dev_o.ctrl_wr |-> $past(!dev_en))
        else $error("control written while enable still set");
    refuse_quiet_a: assert property (
        @(posedge pclk) disable iff (!presetn || !ce)
        start && refuse |=> idle && ref_q && done_q && !dev_o.ctrl_wr)
        else $error("refused command reached the device");
    read_done_a: assert property (
        @(posedge pclk) disable iff (!presetn || !ce)
        dev_o.lpm |=> st_q == S_FIN ##1 (idle && done_q))
        else $error("read result not captured in time");
    ptr_hold_a: assert property (
        @(posedge pclk) disable iff (!presetn || !ce)
        !idle |=> $stable(z_q) && $stable(data_q))
        else $error("pointer or data changed while busy");
    lock_only_a: assert property (
        @(posedge pclk) disable iff (!presetn || !ce)
        dev_o.ctrl_wr && op_q == OP_LOCK |-> dev_o.ctrl_wdata == CTRL_LOCK
        && dev_o.r[15:8] == 8'h00)
        else $error("lock set pattern or high byte wrong");
endmodule

// >>> flash_host_pkg.sv
package flash_host_pkg;
    localparam logic [7:0] REG_CMD  = 8'h00;
    localparam logic [7:0] REG_ADDR = 8'h04;
    localparam logic [7:0] REG_DATA = 8'h08;
    localparam logic [7:0] REG_STAT = 8'h0C;
    localparam logic [2:0] OP_LOAD  = 3'h1;
    localparam logic [2:0] OP_ERASE = 3'h2;
    localparam logic [2:0] OP_WRITE = 3'h3;
    localparam logic [2:0] OP_LOCK  = 3'h4;
    localparam logic [2:0] OP_REEN  = 3'h5;
    localparam logic [2:0] OP_FUSE  = 3'h6;
    localparam logic [2:0] OP_SIG   = 3'h7;
    localparam logic [7:0] CTRL_LOAD  = 8'h01;
    localparam logic [7:0] CTRL_ERASE = 8'h03;
    localparam logic [7:0] CTRL_WRITE = 8'h05;
    localparam logic [7:0] CTRL_LOCK  = 8'h09;
    localparam logic [7:0] CTRL_REEN  = 8'h11;
    localparam logic [7:0] CTRL_SIG   = 8'h21;
    localparam int         EN_BIT   = 0;
    localparam int         PAGE_HI  = 13;
    localparam int         PAGE_LO  = 7;
    localparam int         WORD_HI  = 6;
    localparam int         WORD_LO  = 1;
    localparam logic [15:0] LOCK_Z    = 16'h0001;
    localparam logic [7:0]  LOCK_KEEP = 8'hC3;
    localparam int         ST_BUSY  = 0;
    localparam int         ST_DONE  = 1;
    localparam int         ST_REF   = 2;
    localparam int         ST_RES   = 8;
    localparam int         ST_CTRL  = 16;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;

    typedef struct packed {
        logic        ctrl_wr;
        logic [7:0]  ctrl_wdata;
        logic        spm;
        logic        lpm;
        logic [15:0] z;
        logic [15:0] r;
    } dev_out_s;

    typedef struct packed {
        logic [7:0] ctrl_rdata;
        logic [7:0] lpm_data;
        logic       eeprom_write_busy;
    } dev_in_s;
endpackage

// >>> dev_model.sv
`timescale 1ns/1ps
module dev_model
    import flash_host_pkg::*;
#(
    parameter logic [7:0] FLO = 8'h62,
    parameter logic [7:0] FHI = 8'hD9,
    parameter logic [7:0] SG0 = 8'h5A,
    parameter logic [7:0] SG1 = 8'hA5,
    parameter logic [7:0] SG2 = 8'h3C
)(
    input  wire logic     pclk,
    input  wire logic     presetn,
    input  wire logic     ee_busy,
    input  wire dev_out_s dev_o,
    output dev_in_s       dev_i
);
    // signature values are arbitrary
    logic [7:0] ctl_q;
    logic [7:0] lock_q;
    logic [7:0] rd_q;
    logic [2:0] win_q;
    logic [3:0] bsy_q;
    logic [63:0] fill_q;
    logic [6:0] page_q;
    logic       wr_q;
    wire  [5:0] pat = ctl_q[5:0];
    wire        pg  = (pat == 6'h03) || (pat == 6'h05);
    // request is up while control bit 7 is set and enable reads clear
    wire        ready_irq = ctl_q[7] && !ctl_q[0];
    wire  [15:0] z  = dev_o.z;
    wire  [7:0] fz  = (z == 16'h0000) ? FLO : (z == 16'h0001) ? lock_q : FHI;
    wire  [7:0] sz  = (z == 16'h0000) ? SG0 : (z == 16'h0002) ? SG1 :
                      (z == 16'h0004) ? SG2 : 8'hFF;
    assign dev_i = '{ctrl_rdata: ctl_q, lpm_data: rd_q,
                     eeprom_write_busy: ee_busy};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_q  <= 8'h00;
            lock_q <= 8'hFF;
            rd_q   <= 8'h00;
            win_q  <= 3'h0;
            bsy_q  <= 4'h0;
            fill_q <= 64'h0;
            page_q <= 7'h00;
            wr_q   <= 1'b0;
        end else if (dev_o.ctrl_wr && !ee_busy) begin
            ctl_q <= dev_o.ctrl_wdata;
            win_q <= 3'h4;
            if (dev_o.ctrl_wdata[4]) begin
                fill_q <= 64'h0;
            end
        end else if (bsy_q != 4'h0) begin
            bsy_q    <= bsy_q - 4'h1;
            ctl_q[0] <= (bsy_q != 4'h1);
            if (bsy_q == 4'h1 && wr_q) begin
                fill_q <= 64'h0;
            end
        end else if (dev_o.spm && ctl_q[0]) begin
            win_q <= 3'h0;
            bsy_q <= pg ? 4'hF : 4'h0;
            ctl_q <= pg ? 8'h41 : 8'h00;
            wr_q  <= (pat == 6'h05);
            if (pg) begin
                page_q <= z[PAGE_HI:PAGE_LO];
            end
            if (pat == 6'h01) begin
                fill_q[z[WORD_HI:WORD_LO]] <= 1'b1;
            end
            if (pat == 6'h09) begin
                lock_q[5:2] <= lock_q[5:2] & dev_o.r[5:2];
            end
        end else if (dev_o.lpm && ctl_q[0]) begin
            rd_q  <= ctl_q[3] ? fz : sz;
            ctl_q <= 8'h00;
            win_q <= 3'h0;
        end else if (win_q != 3'h0) begin
            win_q <= win_q - 3'h1;
            ctl_q <= (win_q == 3'h1) ? 8'h00 : ctl_q;
        end
    end
endmodule

// >>> flash_host_test.sv
`timescale 1ns/1ps
module flash_host_test
    import flash_host_pkg::*;
;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic ee_busy = 0, ce = 1, pslverr, pready, se;
    logic [7:0]  paddr = 8'h00, cw;
    logic [31:0] pwdata = 32'h0, prdata, st;
    logic [15:0] cz, cr;
    int err_total = 0, comparisons = 0, wr_n = 0;
    dev_in_s  dev_i;
    dev_out_s dev_o;
    always #50 pclk = ~pclk;
    flash_host i_flash_host (.pclk(pclk), .presetn(presetn), .ce(ce),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .dev_i(dev_i), .dev_o(dev_o));
    dev_model i_dev_model (.pclk(pclk), .presetn(presetn),
        .ee_busy(ee_busy), .dev_o(dev_o), .dev_i(dev_i));
    always @(posedge pclk) begin
        if (dev_o.ctrl_wr === 1'b1) begin
            wr_n++;
            cw = dev_o.ctrl_wdata;
            cz = dev_o.z;
            cr = dev_o.r;
        end
    end
    task automatic results();
        if (err_total == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] s, e);
        comparisons++;
        if (s !== e) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        se = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask
    task automatic start(input logic [2:0] op, input logic [15:0] z, d);
        logic [31:0] q;
        apb(1, REG_ADDR, {16'h0, z}, q);
        apb(1, REG_DATA, {16'h0, d}, q);
        apb(1, REG_CMD, {29'h0, op}, q);
    endtask
    task automatic wait_done();
        int n;
        n = 0;
        st = 0;
        while (st[ST_DONE] !== 1'b1 && n < 200) begin
            apb(0, REG_STAT, 0, st);
            n++;
        end
        check("done", st[ST_DONE], 1);
    endtask
    task automatic run(input logic [2:0] op, input logic [15:0] z, d);
        start(op, z, d);
        wait_done();
    endtask
    task automatic t_reset();
        apb(0, REG_STAT, 0, st);
        check("status", st[2:0], 0);
        apb(0, 8'h10, 0, st);
        check("slverr", se, 1);
        apb(0, REG_CMD, 0, st);
        check("cmdrd", st, 0);
    endtask
    task automatic t_load();
        run(OP_LOAD, 16'h0086, 16'hBEEF);
        check("pattern", cw, CTRL_LOAD);
        check("data", cr, 16'hBEEF);
        check("word", cz[WORD_HI:WORD_LO], 3);
        check("fill", i_dev_model.fill_q[3], 1);
        apb(0, REG_ADDR, 0, st);
        check("zrd", st, 32'h0000_0086);
        run(OP_LOAD, 16'h0086, 16'h1234);
        check("dup", st[ST_REF], 1);
        check("writes", wr_n, 1);
    endtask
    task automatic t_pages();
        run(OP_ERASE, 16'h0100, 0);
        check("erase", cw, CTRL_ERASE);
        check("page", cz[PAGE_HI:PAGE_LO], 2);
        check("latch", i_dev_model.page_q, 2);
        check("rwwbusy", st[ST_CTRL+6], 1);
        run(OP_WRITE, 16'h0100, 0);
        check("write", cw, CTRL_WRITE);
        check("ok", st[ST_REF], 0);
        check("flushed", i_dev_model.fill_q == 64'h0, 1);
        run(OP_WRITE, 16'h0100, 0);
        check("rewrite", st[ST_REF], 1);
        run(OP_REEN, 0, 0);
        check("reen", cw, CTRL_REEN);
        check("rwwfree", st[ST_CTRL+6], 0);
    endtask
    task automatic t_lock();
        run(OP_LOCK, 16'h0000, 16'h0000);
        check("lock", cw, CTRL_LOCK);
        check("lockz", cz, LOCK_Z);
        check("r0", cr[7:0], LOCK_KEEP);
        run(OP_FUSE, 16'h0001, 0);
        check("rd", cw, CTRL_LOCK);
        check("locks", st[15:8], 8'hC3);
        run(OP_FUSE, 16'h0000, 0);
        check("flo", st[15:8], 8'h62);
        run(OP_FUSE, 16'h0003, 0);
        check("fhi", st[15:8], 8'hD9);
    endtask
    task automatic t_sig();
        logic [7:0] e[3] = '{8'h5A, 8'hA5, 8'h3C};
        for (int i = 0; i < 3; i++) begin
            run(OP_SIG, 16'(2 * i), 0);
            check("sigcmd", cw, CTRL_SIG);
            check("sig", st[15:8], e[i]);
        end
    endtask
    task automatic t_ee();
        int n;
        n = wr_n;
        start(3'h0, 0, 0);
        repeat (10) @(posedge pclk);
        check("op0", wr_n, n);
        ee_busy <= 1;
        start(OP_REEN, 0, 0);
        repeat (20) @(posedge pclk);
        check("held", wr_n, n);
        apb(0, REG_STAT, 0, st);
        check("busy", st[ST_BUSY], 1);
        ce <= 0;
        ee_busy <= 0;
        repeat (10) @(posedge pclk);
        check("frozen", wr_n, n);
        ce <= 1;
        wait_done();
        check("after", wr_n, n + 1);
        check("irq", i_dev_model.ready_irq, 0);
    endtask
    task automatic t_rst();
        run(OP_LOAD, 16'h0002, 16'h0055);
        check("fill1", i_dev_model.fill_q[1], 1);
        presetn <= 0;
        repeat (2) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        check("cleared", i_dev_model.fill_q == 64'h0, 1);
        apb(0, REG_STAT, 0, st);
        check("rststat", st[2:0], 0);
        run(OP_LOAD, 16'h0002, 16'h0066);
        check("reload", st[ST_REF], 0);
        check("reloaded", cr, 16'h0066);
    endtask
    initial begin
        #(100 * 20000);
        err_total++;
        results();
    end
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        t_reset();
        t_load();
        t_pages();
        t_lock();
        t_sig();
        t_ee();
        t_rst();
        results();
    end
endmodule
